/* File: vims_dispatch.sv */
`include "vims_cfg.svh"
module vims_dispatch #(
   parameter int NSRC = `VIMS_NUM_SRC,
   parameter int PW = 8
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Interrupt sources (single-cycle pulses, same clock)
   input wire logic i_nmi_pin,
   input wire logic i_watchdog_overflow_request,
   input wire logic [NSRC-1:0] i_src_req,
   input wire logic i_sync1_transfer_done_request,
   input wire logic i_sync2_transfer_done_request,
   // Per-source setup
   input wire logic [NSRC-1:0] i_mask,
   input wire logic [NSRC-1:0] i_ms_enable,
   input wire logic [NSRC-1:0] i_ctx_enable,
   input wire logic [2*NSRC-1:0] i_prio,
   input wire logic [`VIMS_MS_CNT_W-1:0] i_ms_count,
   // CPU core
   input wire logic i_software_break_instr,
   input wire logic i_break_bank_switch_instr,
   input wire logic [`VIMS_BANK_W-1:0] i_bank_sel,
   input wire logic i_operand_error,
   input wire logic i_return_from_interrupt_instr,
   input wire logic i_cpu_ack,
   input wire logic i_cpu_halted,
   input wire logic i_ms_done,
   // Real-time output data
   input wire logic [PW-1:0] i_ms_pattern,
   input wire logic [15:0] i_ms_interval,
   input wire logic [15:0] i_timer1_count_reg,
   // Outputs
   output vims_pkg::vims_cpu_cmd_s o_cpu_cmd,
   output vims_pkg::vims_ms_xfer_s o_ms_xfer,
   output logic [2:0] o_cur_level,
   output logic [PW-1:0] o_rto_port0,
   output logic [PW-1:0] o_rto_port1
);
   // =====================================================
   // State
   typedef struct packed {
      vims_pkg::vims_state_e state;
      vims_pkg::vims_cpu_cmd_s cmd;
      vims_pkg::vims_ms_xfer_s ms;
      logic [NSRC-1:0] pend;
      logic [`VIMS_NUM_LVL-1:0] lvl_stack;
      logic [2:0] cur_lvl;
      logic [2:0] new_lvl;
      logic [NSRC*`VIMS_MS_CNT_W-1:0] left;
      logic nmi_pend;
      logic wdt_pend;
      logic [1:0] rto_load;
      logic [3*`VIMS_NUM_LVL-1:0] lvl_save; // Saved levels; oldest lost past four
      logic [2:0] nmi_sync; // Pin synchroniser, then edge stage
   } vims_st_s;
   vims_st_s st_ff, nxt_st;
   logic [NSRC-1:0] req_in;
   logic [1:0] rto_match;
   logic [1:0] rto_match_q;
   logic [2*PW-1:0] rto_port;
   // Shared slots: either source sets the request
   always_comb begin
      req_in = i_src_req;
      req_in[`VIMS_SRC_SR0] = i_src_req[`VIMS_SRC_SR0] | i_sync1_transfer_done_request;
      req_in[`VIMS_SRC_SR2] = i_src_req[`VIMS_SRC_SR2] | i_sync2_transfer_done_request;
      req_in[`VIMS_SRC_C10] = i_src_req[`VIMS_SRC_C10] | (rto_match[0] & ~rto_match_q[0]);
      req_in[`VIMS_SRC_C11] = i_src_req[`VIMS_SRC_C11] | (rto_match[1] & ~rto_match_q[1]);
   end

   // =====================================================
   // Next-state logic
   always_comb begin
      logic found;
      logic [`VIMS_SRC_IDX_W-1:0] win;
      logic [1:0] win_lvl;
      logic [`VIMS_MS_CNT_W-1:0] cnt;
      found = 1'b0;
      win = '0;
      win_lvl = 2'h3;
      cnt = '0;
      nxt_st = st_ff;
      nxt_st.rto_load = 2'h0;
      // Set wins over a same-cycle clear
      nxt_st.pend = st_ff.pend | req_in;
      nxt_st.nmi_sync = {st_ff.nmi_sync[1:0], i_nmi_pin}; // Two flops before any use
      nxt_st.nmi_pend = st_ff.nmi_pend | (st_ff.nmi_sync[1] & ~st_ff.nmi_sync[2]);
      nxt_st.wdt_pend = st_ff.wdt_pend | i_watchdog_overflow_request;
      // Winner: lowest level number, lowest index on ties; a macro-service source replaces any higher-index candidate
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (st_ff.pend[i] && !i_mask[i]
             && (i_ms_enable[i]
                 || ({1'b0, i_prio[2*i +: 2]} < st_ff.cur_lvl))) begin
            if (!found || i_ms_enable[i] || i_prio[2*i +: 2] <= win_lvl) begin
               found = 1'b1;
               win = 5'(i);
               win_lvl = i_prio[2*i +: 2];
            end
         end
      end
      case (st_ff.state)
         vims_pkg::VIMS_IDLE: begin
            nxt_st.cmd.req = 1'b0;
            nxt_st.ms.valid = 1'b0;
            if (i_return_from_interrupt_instr && st_ff.lvl_stack[0]) begin
               nxt_st.state = vims_pkg::VIMS_POP;
               nxt_st.cmd = '0;
               nxt_st.cmd.req = 1'b1;
               nxt_st.cmd.pop_ctx = 1'b1;
            end else if (i_software_break_instr || i_operand_error || i_break_bank_switch_instr
                         || st_ff.nmi_pend || st_ff.wdt_pend) begin
               nxt_st.state = vims_pkg::VIMS_VECTOR;
               nxt_st.cmd = '0;
               nxt_st.cmd.req = 1'b1;
               nxt_st.cmd.push_ctx = 1'b1;
               nxt_st.new_lvl = st_ff.cur_lvl;
               if (i_break_bank_switch_instr) begin
                  nxt_st.cmd.push_ctx = 1'b0;
                  nxt_st.cmd.ctx_switch = 1'b1;
                  nxt_st.cmd.bank = i_bank_sel;
               end else if (i_software_break_instr) begin
                  nxt_st.cmd.vector = `VIMS_VEC_BRK;
               end else if (i_operand_error) begin
                  nxt_st.cmd.vector = `VIMS_VEC_OPERR;
               end else if (st_ff.nmi_pend) begin
                  nxt_st.cmd.vector = `VIMS_VEC_NMI;
                  nxt_st.nmi_pend = st_ff.nmi_sync[1] & ~st_ff.nmi_sync[2];
                  nxt_st.new_lvl = 3'h0;
               end else begin
                  nxt_st.cmd.vector = `VIMS_VEC_WDT;
                  nxt_st.wdt_pend = i_watchdog_overflow_request;
                  nxt_st.new_lvl = 3'h0;
               end
            end else if (found) begin
               nxt_st.pend[win] = req_in[win];
               cnt = st_ff.left[win*`VIMS_MS_CNT_W +: `VIMS_MS_CNT_W];
               if (i_ms_enable[win] && cnt != '0) begin
                  // No context save and no fetch, CPU may be halted
                  nxt_st.state = vims_pkg::VIMS_MS_XFER;
                  nxt_st.ms.valid = 1'b1;
                  nxt_st.ms.src = win;
                  nxt_st.ms.chan = (win == `VIMS_SRC_C11);
                  if (win == `VIMS_SRC_ST0 || win == `VIMS_SRC_ST2) begin
                     nxt_st.ms.kind = vims_pkg::VIMS_MS_TX;
                  end else if (win == `VIMS_SRC_C10 || win == `VIMS_SRC_C11) begin
                     nxt_st.ms.kind = vims_pkg::VIMS_MS_RTO;
                  end else begin
                     nxt_st.ms.kind = vims_pkg::VIMS_MS_RX;
                  end
                  nxt_st.left[win*`VIMS_MS_CNT_W +: `VIMS_MS_CNT_W] = cnt - 1'b1;
               end else begin
                  // Last item done or plain source: vectored interrupt
                  nxt_st.state = vims_pkg::VIMS_VECTOR;
                  nxt_st.left[win*`VIMS_MS_CNT_W +: `VIMS_MS_CNT_W] = i_ms_count;
                  nxt_st.cmd = '0;
                  nxt_st.cmd.req = 1'b1;
                  nxt_st.cmd.vector = `VIMS_VEC_MASK_BASE
                                      + 16'({11'h0, win} * `VIMS_VEC_STEP);
                  nxt_st.cmd.ctx_switch = i_ctx_enable[win];
                  nxt_st.cmd.push_ctx = ~i_ctx_enable[win];
                  nxt_st.cmd.bank = i_bank_sel;
                  nxt_st.new_lvl = {1'b0, win_lvl};
               end
            end
         end
         vims_pkg::VIMS_VECTOR: begin
            if (i_cpu_ack) begin
               nxt_st.state = vims_pkg::VIMS_IDLE;
               nxt_st.cmd.req = 1'b0;
               nxt_st.lvl_stack = {st_ff.lvl_stack[`VIMS_NUM_LVL-2:0], 1'b1};
               nxt_st.lvl_save = {st_ff.lvl_save[3*`VIMS_NUM_LVL-4:0], st_ff.cur_lvl};
               nxt_st.cur_lvl = st_ff.new_lvl;
            end
         end
         vims_pkg::VIMS_POP: begin
            if (i_cpu_ack) begin
               nxt_st.state = vims_pkg::VIMS_IDLE;
               nxt_st.cmd.req = 1'b0;
               nxt_st.lvl_stack = {1'b0, st_ff.lvl_stack[`VIMS_NUM_LVL-1:1]};
               nxt_st.lvl_save = {`VIMS_IDLE_LVL, st_ff.lvl_save[3*`VIMS_NUM_LVL-1:3]};
               nxt_st.cur_lvl = st_ff.lvl_save[2:0];
            end
         end
         vims_pkg::VIMS_MS_XFER: begin
            if (i_ms_done) begin
               nxt_st.state = vims_pkg::VIMS_IDLE;
               nxt_st.ms.valid = 1'b0;
               if (st_ff.ms.kind == vims_pkg::VIMS_MS_RTO) begin
                  nxt_st.rto_load[st_ff.ms.chan] = 1'b1;
               end
            end
         end
         default: begin
            nxt_st.state = vims_pkg::VIMS_IDLE;
         end
      endcase
   end
   // State register; counters and saved levels clear with the rest
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         st_ff <= '0;
         st_ff.cur_lvl <= `VIMS_IDLE_LVL;
         rto_match_q <= 2'h0;
      end else begin
         st_ff <= nxt_st;
         rto_match_q <= rto_match;
      end
   end
   // =====================================================
   // Two real-time output channels
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_rto
         vims_rto_chan #(.W(PW)) u_chan (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_load(st_ff.rto_load[g]),
            .i_pattern(i_ms_pattern),
            .i_interval(i_ms_interval),
            .i_timer1_count_reg(i_timer1_count_reg),
            .o_match(rto_match[g]),
            .o_port_latch(rto_port[g*PW +: PW])
         );
      end
   endgenerate
   assign o_cpu_cmd = st_ff.cmd;
   assign o_ms_xfer = st_ff.ms;
   assign o_cur_level = st_ff.cur_lvl;
   assign o_rto_port0 = rto_port[PW-1:0];
   assign o_rto_port1 = rto_port[2*PW-1:PW];
   // =====================================================
   // Checks
   property p_ms_no_ctx;
      @(posedge i_clk_sys) disable iff (i_srst)
      o_ms_xfer.valid |-> !o_cpu_cmd.req;
   endproperty
   a_ms_no_ctx: assert property (p_ms_no_ctx) else $error("ms raised cpu request");
   property p_brk_vec;
      @(posedge i_clk_sys) disable iff (i_srst)
      (st_ff.state == vims_pkg::VIMS_IDLE && i_software_break_instr
       && !i_return_from_interrupt_instr) |=> o_cpu_cmd.vector == `VIMS_VEC_BRK;
   endproperty
   a_brk_vec: assert property (p_brk_vec) else $error("break vector wrong");
   property p_vec_push;
      @(posedge i_clk_sys) disable iff (i_srst)
      (o_cpu_cmd.req && !o_cpu_cmd.pop_ctx) |-> (o_cpu_cmd.push_ctx ^ o_cpu_cmd.ctx_switch);
   endproperty
   a_vec_push: assert property (p_vec_push) else $error("entry save missing");
   property p_pop_ret;
      @(posedge i_clk_sys) disable iff (i_srst)
      $rose(o_cpu_cmd.pop_ctx) |-> $past(i_return_from_interrupt_instr);
   endproperty
   a_pop_ret: assert property (p_pop_ret) else $error("pop without return");
   property p_vec_range;
      @(posedge i_clk_sys) disable iff (i_srst)
      (o_cpu_cmd.req && o_cpu_cmd.push_ctx) |-> o_cpu_cmd.vector <= `VIMS_VEC_BRK
                                               && !o_cpu_cmd.vector[0];
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector outside table");
   property p_ms_halt;
      @(posedge i_clk_sys) disable iff (i_srst)
      (o_ms_xfer.valid && i_ms_done) |=> !o_ms_xfer.valid;
   endproperty
   a_ms_halt: assert property (p_ms_halt) else $error("ms transfer stuck");
   property p_lvl_after_ack;
      @(posedge i_clk_sys) disable iff (i_srst)
      (st_ff.state == vims_pkg::VIMS_VECTOR && i_cpu_ack) |=> o_cur_level == $past(st_ff.new_lvl);
   endproperty
   a_lvl_after_ack: assert property (p_lvl_after_ack) else $error("level not taken");
   property p_rto_load;
      @(posedge i_clk_sys) disable iff (i_srst)
      (o_ms_xfer.valid && i_ms_done && o_ms_xfer.kind == vims_pkg::VIMS_MS_RTO)
      |=> st_ff.rto_load != 2'h0;
   endproperty
   a_rto_load: assert property (p_rto_load) else $error("rto not loaded");
endmodule

/* File: vims_cfg.svh */
`ifndef VIMS_CFG_SVH
`define VIMS_CFG_SVH
// =====================================================
// Vector slots
`define VIMS_VEC_BRK 16'h003E
`define VIMS_VEC_OPERR 16'h003C
`define VIMS_VEC_NMI 16'h0002
`define VIMS_VEC_WDT 16'h0004
`define VIMS_VEC_MASK_BASE 16'h0006
`define VIMS_VEC_STEP 16'h0002
// =====================================================
// Sizes and reset values
`define VIMS_NUM_SRC 21
`define VIMS_SRC_IDX_W 5
`define VIMS_NUM_LVL 4
`define VIMS_BANK_W 3
`define VIMS_IDLE_LVL 3'h4
`define VIMS_MS_CNT_W 8
// =====================================================
// Source indices within the maskable set
`define VIMS_SRC_C10 6
`define VIMS_SRC_C11 7
`define VIMS_SRC_SR0 15
`define VIMS_SRC_ST0 16
`define VIMS_SRC_SR2 19
`define VIMS_SRC_ST2 20
`endif

/* File: vims_pkg.sv */
`include "vims_cfg.svh"
package vims_pkg;
   // Dispatcher states
   typedef enum logic [2:0] {
      VIMS_IDLE, VIMS_PUSH, VIMS_VECTOR, VIMS_POP, VIMS_MS_XFER
   } vims_state_e;
   // Kind of macro service action
   typedef enum logic [1:0] {
      VIMS_MS_TX, VIMS_MS_RX, VIMS_MS_RTO
   } vims_ms_kind_e;
   // Request toward the CPU core
   typedef struct packed {
      logic req;
      logic [15:0] vector;
      logic push_ctx;
      logic pop_ctx;
      logic ctx_switch;
      logic [`VIMS_BANK_W-1:0] bank;
   } vims_cpu_cmd_s;
   // Macro service memory/register transfer
   typedef struct packed {
      logic valid;
      vims_ms_kind_e kind;
      logic [`VIMS_SRC_IDX_W-1:0] src;
      logic chan;
   } vims_ms_xfer_s;
endpackage

/* File: vims_rto_chan.sv */
`include "vims_cfg.svh"
// =====================================================
// Real-time output channel: compare, pattern and latch
module vims_rto_chan #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Service loads
   input wire logic i_load,
   input wire logic [W-1:0] i_pattern,
   input wire logic [15:0] i_interval,
   // Timer
   input wire logic [15:0] i_timer1_count_reg,
   // Outputs
   output logic o_match,
   output logic [W-1:0] o_port_latch
);
   // Channel state
   typedef struct packed {
      logic [W-1:0] rto_pattern_buffer;
      logic [15:0] timer1_compare_reg;
      logic [W-1:0] latch;
      logic match;
   } vims_rto_st_s;
   vims_rto_st_s st_ff, nxt_st;

   // Load on service, transfer buffer on compare match
   always_comb begin
      nxt_st = st_ff;
      nxt_st.match = (i_timer1_count_reg == st_ff.timer1_compare_reg);
      if (nxt_st.match && !st_ff.match) begin
         nxt_st.latch = st_ff.rto_pattern_buffer;
      end
      if (i_load) begin
         nxt_st.rto_pattern_buffer = i_pattern;
         nxt_st.timer1_compare_reg = i_interval;
      end
   end

   // State register
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_match = st_ff.match & 1'b1;
   assign o_port_latch = st_ff.latch;

   // Latch shows last cycle's buffer in the same cycle a fresh match shows
   property p_rto_latch;
      @(posedge i_clk_sys) disable iff (i_srst)
      (o_match && !$past(o_match)) |-> o_port_latch == $past(st_ff.rto_pattern_buffer);
   endproperty
   a_rto_latch: assert property (p_rto_latch) else $error("pattern not latched");
endmodule

/* File: vims_cpu_model.sv */
// =====================================================
// Core model: acknowledges dispatch and transfer requests
module vims_cpu_model (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // Requests from the dispatcher
   input wire vims_pkg::vims_cpu_cmd_s i_cpu_cmd,
   input wire vims_pkg::vims_ms_xfer_s i_ms_xfer,
   // Answer delay in cycles, 0 = prompt
   input wire logic [3:0] i_delay,
   // Answers
   output logic o_cpu_ack,
   output logic o_ms_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_a; // Wait count for dispatch
   logic [3:0] cnt_m; // Wait count for transfer
   logic held_a; // Acked, waiting for request to drop
   logic held_m; // Done given, waiting for valid to drop
   // One ack per request; a held flag stops a second ack while req still stands
   always_ff @(posedge i_clk_sys) begin
      o_cpu_ack <= 1'b0;
      o_ms_done <= 1'b0;
      if (i_srst) begin
         cnt_a <= 4'h0;
         cnt_m <= 4'h0;
         held_a <= 1'b0;
         held_m <= 1'b0;
      end else begin
         // Handler runs; ack once req has stood i_delay cycles
         if (!i_cpu_cmd.req) begin
            cnt_a <= 4'h0;
            held_a <= 1'b0;
         end else if (!held_a) begin
            if (cnt_a >= i_delay) begin
               o_cpu_ack <= 1'b1;
               held_a <= 1'b1;
            end else begin
               cnt_a <= cnt_a + 4'h1;
            end
         end
         // Transfer done after the same delay
         if (!i_ms_xfer.valid) begin
            cnt_m <= 4'h0;
            held_m <= 1'b0;
         end else if (!held_m) begin
            if (cnt_m >= i_delay) begin
               o_ms_done <= 1'b1;
               held_m <= 1'b1;
            end else begin
               cnt_m <= cnt_m + 4'h1;
            end
         end
      end
   end
endmodule

/* File: tb_vectored_interrupt_macro_service.sv */
// =====================================================
// Bench for the dispatcher
module tb_vectored_interrupt_macro_service;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic nmi = 1'b0, wdt = 1'b0, sy1 = 1'b0, sy2 = 1'b0;
   logic software_break_instr = 1'b0, break_bank_switch_instr = 1'b0, operr = 1'b0, return_from_interrupt_instr = 1'b0, halted = 1'b1;
   logic [20:0] src = 21'h0, mask = 21'h0, ms_en = 21'h0, ctx_en = 21'h0;
   logic [41:0] prio = 42'h0;
   logic [7:0] ms_count = 8'h04, pattern = 8'h00;
   logic [15:0] interval = 16'h0100, timer = 16'hFFFF;
   logic [3:0] delay = 4'h0;
   logic cpu_ack, ms_done;
   vims_pkg::vims_cpu_cmd_s o_cpu_cmd;
   vims_pkg::vims_ms_xfer_s o_ms_xfer;
   logic [2:0] o_cur_level;
   logic [7:0] port0, port1;
   int mismatches = 0, checks_done = 0, cycles = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   vims_dispatch i_vims_dispatch (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_nmi_pin(nmi),
      .i_watchdog_overflow_request(wdt), .i_src_req(src), .i_sync1_transfer_done_request(sy1),
      .i_sync2_transfer_done_request(sy2), .i_mask(mask), .i_ms_enable(ms_en),
      .i_ctx_enable(ctx_en), .i_prio(prio), .i_ms_count(ms_count),
      .i_software_break_instr(software_break_instr), .i_break_bank_switch_instr(break_bank_switch_instr), .i_bank_sel(3'h5),
      .i_operand_error(operr), .i_return_from_interrupt_instr(return_from_interrupt_instr), .i_cpu_ack(cpu_ack),
      .i_cpu_halted(halted), .i_ms_done(ms_done), .i_ms_pattern(pattern),
      .i_ms_interval(interval), .i_timer1_count_reg(timer), .o_cpu_cmd(o_cpu_cmd),
      .o_ms_xfer(o_ms_xfer), .o_cur_level(o_cur_level), .o_rto_port0(port0),
      .o_rto_port1(port1));
   vims_cpu_model i_vims_cpu_model (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
      .i_cpu_cmd(o_cpu_cmd), .i_ms_xfer(o_ms_xfer), .i_delay(delay), .o_cpu_ack(cpu_ack),
      .o_ms_done(ms_done));
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic do_reset(input int n);
      i_srst = 1'b1;
      tick(n);
      i_srst = 1'b0;
   endtask
   // Wait for a dispatch, judge it, then let the model acknowledge it
   task automatic take(input logic [15:0] vec, input logic push);
      int n;
      n = 0;
      while (o_cpu_cmd.req !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      check({31'h0, o_cpu_cmd.req}, 32'h1);
      check({16'h0, o_cpu_cmd.vector}, {16'h0, vec});
      check({31'h0, o_cpu_cmd.push_ctx}, {31'h0, push});
      n = 0;
      while (o_cpu_cmd.req === 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      tick(1);
   endtask
   // Handler ends with the return instruction
   task automatic do_ret();
      return_from_interrupt_instr = 1'b1;
      tick(1);
      return_from_interrupt_instr = 1'b0;
      while (o_cpu_cmd.req !== 1'b1 && cycles < 19000) tick(1);
      check({31'h0, o_cpu_cmd.pop_ctx}, 32'h1);
      while (o_cpu_cmd.req === 1'b1 && cycles < 19000) tick(1);
      tick(1);
   endtask
   task automatic pulse_src(input logic [20:0] v);
      src = v;
      tick(1);
      src = 21'h0;
   endtask
   // Every maskable source reaches its own slot; level follows
   task automatic t_vectors();
      for (int i = 0; i < 21; i++) begin
         delay = i[0] ? 4'h3 : 4'h0;
         pulse_src(21'h1 << i);
         take(16'h0006 + 16'(2 * i), 1'b1);
         check({29'h0, o_cur_level}, 32'h0);
         do_ret();
         check({29'h0, o_cur_level}, 32'h4);
      end
      $display("test vectors done");
   endtask
   // Fixed slots for software, error and nonmaskable sources
   task automatic t_fixed();
      software_break_instr = 1'b1;
      tick(1);
      software_break_instr = 1'b0;
      take(16'h003E, 1'b1);
      do_ret();
      operr = 1'b1;
      tick(1);
      operr = 1'b0;
      take(16'h003C, 1'b1);
      do_ret();
      nmi = 1'b1;
      tick(1);
      nmi = 1'b0;
      take(16'h0002, 1'b1);
      do_ret();
      wdt = 1'b1;
      tick(1);
      wdt = 1'b0;
      take(16'h0004, 1'b1);
      do_ret();
      break_bank_switch_instr = 1'b1;
      tick(1);
      break_bank_switch_instr = 1'b0;
      while (o_cpu_cmd.req !== 1'b1 && cycles < 19000) tick(1);
      check({28'h0, o_cpu_cmd.ctx_switch, o_cpu_cmd.bank}, 32'hD);
      while (o_cpu_cmd.req === 1'b1 && cycles < 19000) tick(1);
      do_ret();
      $display("test fixed done");
   endtask
   // Ties by default order, no preemption at equal level, nesting at higher
   task automatic t_order();
      pulse_src(21'h100001);
      take(16'h0006, 1'b1);
      pulse_src(21'h000008);
      tick(6);
      check({31'h0, o_cpu_cmd.req}, 32'h0);
      do_ret();
      take(16'h000C, 1'b1);
      do_ret();
      take(16'h002E, 1'b1);
      do_ret();
      prio = 42'h0;
      prio[18 +: 2] = 2'h2;
      prio[8 +: 2] = 2'h1;
      pulse_src(21'h1 << 9);
      take(16'h0018, 1'b1);
      pulse_src(21'h1 << 4);
      take(16'h000E, 1'b1);
      check({29'h0, o_cur_level}, 32'h1);
      do_ret();
      do_ret();
      check({29'h0, o_cur_level}, 32'h4);
      prio = 42'h0;
      $display("test order done");
   endtask
   // Shared slots SR0 and SR2 take the sync transfer-done requests
   task automatic t_shared();
      sy1 = 1'b1;
      tick(1);
      sy1 = 1'b0;
      take(16'h0024, 1'b1);
      do_ret();
      sy2 = 1'b1;
      tick(1);
      sy2 = 1'b0;
      take(16'h002C, 1'b1);
      do_ret();
      $display("test shared done");
   endtask
   // Macro service inside a handler, core halted, per kind
   task automatic t_ms(input int s, input vims_pkg::vims_ms_kind_e k, input logic ch);
      do_reset(2);
      check({29'h0, o_cur_level}, 32'h4);
      ms_en = 21'h1 << s;
      prio = 42'h0;
      prio[2 * s +: 2] = 2'h3;
      pattern = 8'h5A ^ 8'(s);
      pulse_src(21'h1 << s);
      take(16'h0006 + 16'(2 * s), 1'b1);
      pulse_src(21'h1 << s);
      while (o_ms_xfer.valid !== 1'b1 && cycles < 19000) tick(1);
      check({29'h0, o_ms_xfer.kind, ch}, {29'h0, k, ch});
      check({27'h0, o_ms_xfer.src}, 32'(s));
      check({31'h0, o_ms_xfer.chan}, {31'h0, ch});
      check({31'h0, o_cpu_cmd.req}, 32'h0);
      while (o_ms_xfer.valid === 1'b1 && cycles < 19000) tick(1);
      if (k == vims_pkg::VIMS_MS_RTO) begin
         timer = interval;
         tick(4);
         timer = 16'hFFFF;
         check({24'h0, ch ? port1 : port0}, {24'h0, pattern});
      end
      ms_en = 21'h0;
      $display("test ms %0d done", s);
   endtask
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      do_reset(20);
      check({o_cpu_cmd, o_ms_xfer}, 32'h0);
      check({29'h0, o_cur_level}, 32'h4);
      $display("test reset done");
      t_vectors();
      t_fixed();
      t_order();
      t_shared();
      t_ms(16, vims_pkg::VIMS_MS_TX, 1'b0);
      t_ms(15, vims_pkg::VIMS_MS_RX, 1'b0);
      t_ms(6, vims_pkg::VIMS_MS_RTO, 1'b0);
      t_ms(7, vims_pkg::VIMS_MS_RTO, 1'b1);
      test_done();
   end
endmodule
